// ==== verif/tb.sv ====
// Purpose: Self-checking bench for the fan channel two register block
// Assumes: One-cycle Wishbone ack; target updates one edge after a sample
// Notes: Small full-speed count keeps the expected counts easy to follow
`timescale 1ns/10ps
`include "fan_ctl_cfg.svh"
module tb;
	logic clock; // 200 MHz clock
	logic rst; // Active high reset
	logic cyc, stb, we; // Wishbone request
	logic [9:0] adr; // Byte address
	logic [3:0] sel; // Byte selects
	logic [31:0] dat_i; // Write data
	logic [31:0] dat_o; // Read data
	logic ack; // Acknowledge
	logic [15:0] fan_count; // Tach count input
	logic [7:0] temp; // Temperature sample
	logic temp_valid; // Sample strobe
	logic [15:0] target_out; // Target pair
	logic duty_mode, auto_mode; // Mode outputs
	int miscompares; // Mismatches seen
	int n_tests; // Comparisons made
	logic [7:0] rdv; // Scratch read value

	fan_two_speed_control_regs uut
	(
		.CLOCK(clock), .RST(rst), .CYC_I(cyc), .STB_I(stb), .WE_I(we),
		.ADR_I(adr), .SEL_I(sel), .DAT_I(dat_i), .DAT_O(dat_o),
		.ACK_O(ack), .FAN_COUNT(fan_count), .TEMP(temp),
		.TEMP_VALID(temp_valid), .TARGET_OUT(target_out),
		.DUTY_MODE(duty_mode), .AUTO_MODE(auto_mode)
	);

	// Free-running clock, 5 ns period
	initial
	begin
		clock = 1'b0;
		forever #2.5 clock = ~clock;
	end

	// Verdict and end of run, the single exit point
	task summarize();
		$display("Comparisons %0d, mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// Compare and count
	task check(input logic [15:0] got, input logic [15:0] exp,
		input string what);
		n_tests++;
		if (got !== exp)
		begin
			miscompares++;
			$display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	// One classic cycle; holds everything until ack is sampled high
	task wb(input logic w, input logic [7:0] idx, input logic [7:0] wd,
		input logic [3:0] s, output logic [7:0] rd);
		int n;
		@(posedge clock);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= {idx, 2'b00};
		sel <= s;
		dat_i <= {24'h000000, wd};
		n = 0;
		@(posedge clock);
		while (ack !== 1'b1 && n < 16)
		begin
			@(posedge clock);
			n++;
		end
		// Bounded wait; a lost ack ends the run
		if (n >= 16)
		begin
			miscompares++;
			$display("MISMATCH t=%0t no ack", $time);
			summarize();
		end
		rd = dat_o[7:0];
		// Unused read lanes must stay zero
		if (!w)
		begin
			check(dat_o[31:16], 16'h0000, "read data upper half");
			check({8'h00, dat_o[15:8]}, 16'h0000, "read data byte one");
		end
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
	endtask

	// Full-byte write
	task wr(input logic [7:0] idx, input logic [7:0] d);
		logic [7:0] dummy;
		wb(1'b1, idx, d, 4'hF, dummy);
	endtask

	// Read and compare one register
	task rd_chk(input logic [7:0] idx, input logic [7:0] exp);
		logic [7:0] v;
		wb(1'b0, idx, 8'h00, 4'hF, v);
		check({8'h00, v}, {8'h00, exp}, "register read");
	endtask

	// One-cycle sample strobe, then look at the target once it landed
	task sample(input logic [7:0] t, input logic [15:0] exp);
		@(posedge clock);
		temp <= t;
		temp_valid <= 1'b1;
		@(posedge clock);
		temp_valid <= 1'b0;
		@(posedge clock);
		check(target_out, exp, "target after sample");
	endtask

	// Reset values of the whole map and the unmapped answer
	task t_reset_values();
		logic [7:0] idx [13];
		logic [7:0] val [13];
		idx = '{8'h96, `IDX_MEAS_HI, `IDX_MEAS_LO, `IDX_TGT_HI, `IDX_TGT_LO,
			`IDX_FULL_HI, `IDX_FULL_LO, `IDX_BOUND_UP, `IDX_BOUND_LO,
			`IDX_HYST, `IDX_SEG_ONE, `IDX_SEG_TWO, `IDX_SEG_THREE};
		val = '{8'h00, 8'h0F, 8'hFF, 8'h00, 8'h01, 8'h03, 8'hFF, 8'h3C,
			8'h1E, 8'h04, 8'hFF, 8'hD9, 8'h80};
		for (int i = 0; i < 13; i++)
			rd_chk(idx[i], val[i]);
		rd_chk(8'h80, 8'h00);
		// Unused mode bits read zero; then back to auto speed mode
		wr(`IDX_MODE_CFG, 8'hFF);
		rd_chk(`IDX_MODE_CFG, 8'h0D);
		wr(`IDX_MODE_CFG, 8'h00);
	endtask

	// Low byte held from the high-byte read while the input moves on
	task t_count_latch();
		fan_count <= 16'h1234;
		repeat (3) @(posedge clock);
		rd_chk(`IDX_MEAS_HI, 8'h12);
		fan_count <= 16'h5678;
		repeat (3) @(posedge clock);
		rd_chk(`IDX_MEAS_LO, 8'h34);
		// Read-only pair ignores writes
		wr(`IDX_MEAS_HI, 8'hAA);
		rd_chk(`IDX_MEAS_HI, 8'h56);
		rd_chk(`IDX_MEAS_LO, 8'h78);
	endtask

	// Full-speed pair ignores a write with no byte lane selected
	task t_full_latch();
		wr(`IDX_FULL_HI, 8'h12);
		wr(`IDX_FULL_LO, 8'h34);
		wb(1'b1, `IDX_FULL_LO, 8'h99, 4'h0, rdv);
		rd_chk(`IDX_FULL_HI, 8'h12);
		rd_chk(`IDX_FULL_LO, 8'h34);
	endtask

	// Speed-count mode, automatic: hysteresis walk over three segments
	task t_speed_auto();
		logic [7:0] t [9];
		logic [15:0] e [9];
		// Full count 64; segment codes 0 (100 %), 21 (60 %), 80h
		wr(`IDX_FULL_HI, 8'h00);
		wr(`IDX_FULL_LO, 8'h40);
		wr(`IDX_SEG_ONE, 8'h00);
		wr(`IDX_SEG_TWO, 8'h15);
		t = '{8'd31, 8'd61, 8'd57, 8'd55, 8'd26, 8'd25, 8'd70, 8'd10, 8'd30};
		e = '{16'd106, 16'd64, 16'd64, 16'd106, 16'd106, 16'd320, 16'd64,
			16'd320, 16'd320};
		for (int i = 0; i < 9; i++)
			sample(t[i], e[i]);
		// No strobe, no change
		temp <= 8'd90;
		repeat (4) @(posedge clock);
		check(target_out, 16'd320, "target without strobe");
		rd_chk(`IDX_TGT_HI, 8'h01);
		wr(`IDX_TGT_LO, 8'h55);
		rd_chk(`IDX_TGT_LO, 8'h40);
	endtask

	// Duty mode: reserved high byte, duty from segments, manual hold
	task t_duty();
		wr(`IDX_MODE_CFG, 8'h04);
		check({15'h0000, duty_mode}, 16'h0001, "duty flag");
		wr(`IDX_TGT_HI, 8'h5A);
		rd_chk(`IDX_TGT_HI, 8'h00);
		wr(`IDX_SEG_ONE, 8'hFF);
		// High byte keeps the last speed count, 01h
		sample(8'd61, 16'h01FF);
		rd_chk(`IDX_TGT_LO, 8'hFF);
		sample(8'd25, 16'h0180);
		// Manual: software owns the duty byte, segment still tracked
		wr(`IDX_MODE_CFG, 8'h0C);
		check({15'h0000, auto_mode}, 16'h0000, "auto flag");
		wr(`IDX_TGT_LO, 8'h33);
		sample(8'd70, 16'h0133);
		wr(`IDX_MODE_CFG, 8'h04);
		sample(8'd58, 16'h01FF);
	endtask

	// Signed boundaries and the negative enable
	task t_negative();
		wr(`IDX_MODE_CFG, 8'h00);
		wr(`IDX_BOUND_UP, 8'hF0);
		rd_chk(`IDX_BOUND_UP, 8'h70);
		wr(`IDX_MODE_CFG, 8'h01);
		wr(`IDX_BOUND_UP, 8'h05);
		wr(`IDX_BOUND_LO, 8'hF6);
		rd_chk(`IDX_BOUND_LO, 8'hF6);
		// -20 is below -10 minus 4; -8 is above -10
		sample(8'hEC, 16'd320);
		sample(8'hF8, 16'd106);
		wr(`IDX_MODE_CFG, 8'h00);
		rd_chk(`IDX_BOUND_LO, 8'h76);
		// Hysteresis keeps only its low four bits
		wr(`IDX_HYST, 8'hF2);
		rd_chk(`IDX_HYST, 8'h02);
	endtask

	// Main sequence
	initial
	begin
		miscompares = 0;
		n_tests = 0;
		rst = 1'b1;
		cyc = 1'b0;
		stb = 1'b0;
		we = 1'b0;
		adr = 10'h000;
		sel = 4'hF;
		dat_i = 32'h00000000;
		fan_count = 16'h0FFF;
		temp = 8'h00;
		temp_valid = 1'b0;
		repeat (16) @(posedge clock);
		// Outputs held at their reset levels
		check(target_out, 16'h0001, "target in reset");
		check({14'h0000, duty_mode, auto_mode}, 16'h0001, "modes in reset");
		rst <= 1'b0;
		t_reset_values();
		t_count_latch();
		t_full_latch();
		t_speed_auto();
		t_duty();
		t_negative();
		summarize();
	end
endmodule

// ==== verilog/fan_ctl_cfg.svh ====
// Purpose: Offsets, field positions, reset values for fan channel two
// Assumes: Register index times four is the Wishbone byte address
// Notes: Included by the register block, speed_count_calc and the bench
// Contract
// - Reading measured high byte latches low byte
// - Speed mode auto control rewrites target count
// - Speed auto mode: low target byte read-only
// - Duty mode: high reserved, low is duty
// - Duty auto mode: hardware updates duty byte
// - Reading full-speed high byte latches low byte
// - Upper boundary with hysteresis picks segment one/two
// - Lower boundary with hysteresis picks segment two/three
// - Boundaries are signed two's complement degrees
// - Negative disabled forces boundary bit seven zero
// - Mode field selects relative speed or duty
`ifndef FAN_CTL_CFG_SVH
`define FAN_CTL_CFG_SVH
// Register indices
`define IDX_MODE_CFG 8'h96
`define IDX_MEAS_HI 8'hB0
`define IDX_MEAS_LO 8'hB1
`define IDX_TGT_HI 8'hB2
`define IDX_TGT_LO 8'hB3
`define IDX_FULL_HI 8'hB4
`define IDX_FULL_LO 8'hB5
`define IDX_BOUND_UP 8'hB6
`define IDX_BOUND_LO 8'hB7
`define IDX_HYST 8'hB8
`define IDX_SEG_ONE 8'hBA
`define IDX_SEG_TWO 8'hBB
`define IDX_SEG_THREE 8'hBE
// Mode register fields
`define CFG_NEG_BIT 0
`define CFG_DUTY_BIT 2
`define CFG_MANUAL_BIT 3
// Reset values
`define RST_MEAS 16'h0FFF
`define RST_MEAS_SHADOW 8'hFF
`define RST_TGT_HI 8'h00
`define RST_TGT_LO 8'h01
`define RST_FULL_HI 8'h03
`define RST_FULL_LO 8'hFF
`define RST_BOUND_UP 8'h3C
`define RST_BOUND_LO 8'h1E
`define RST_SEG_ONE 8'hFF
`define RST_SEG_TWO 8'hD9
`define RST_SEG_THREE 8'h80
`define RST_HYST 4'h4
// Relative speed scale: count = full * (32 + seg) / 32
`define SPEED_SCALE_SHIFT 5
`define SPEED_SCALE_BASE 9'h020
`endif

// ==== verilog/fan_ctl_pkg.sv ====
// Purpose: Types shared by the fan channel two register block
// Assumes: Constants come from fan_ctl_cfg.svh
// Notes: Types only
package fan_ctl_pkg;
	// Active speed segment, one-hot
	typedef enum logic [2:0]
	{
		SEG_ONE = 3'b001,
		SEG_TWO = 3'b010,
		SEG_THREE = 3'b100
	} seg_t;
	// Software mode settings travel together
	typedef struct packed
	{
		logic neg_en;
		logic manual;
		logic duty;
	} mode_cfg_t;
	// Whole state of the register block
	typedef struct packed
	{
		logic ack;
		logic [7:0] rdata;
		logic [15:0] meas;
		logic [7:0] meas_shadow;
		logic [7:0] tgt_hi;
		logic [7:0] tgt_lo;
		logic [7:0] full_hi;
		logic [7:0] full_lo;
		logic [7:0] full_shadow;
		logic [7:0] bound_up;
		logic [7:0] bound_lo;
		logic [3:0] hyst;
		logic [7:0] seg_one;
		logic [7:0] seg_two;
		logic [7:0] seg_three;
		mode_cfg_t cfg;
		seg_t seg;
	} ctl_state_t;
endpackage

// ==== verilog/fan_two_speed_control_regs.sv ====
// Purpose: Register set and automatic control of fan channel two
// Assumes: Classic Wishbone slave, inputs synchronous to CLOCK
// Notes: Byte address is register index times four, data in bits 7:0
//
// The Wishbone register port is this design's own decision.
`timescale 1ns/10ps
`include "fan_ctl_cfg.svh"
module fan_two_speed_control_regs
#(
	parameter int ADDR_W = 10 // Byte address width
)
(
	input wire logic CLOCK, // 200 MHz system clock
	input wire logic RST, // Asynchronous reset, active high
	input wire logic CYC_I, // Wishbone cycle
	input wire logic STB_I, // Wishbone strobe
	input wire logic WE_I, // Wishbone write enable
	input wire logic [ADDR_W-1:0] ADR_I, // Wishbone byte address
	input wire logic [3:0] SEL_I, // Wishbone byte selects
	input wire logic [31:0] DAT_I, // Wishbone write data
	output logic [31:0] DAT_O, // Wishbone read data
	output logic ACK_O, // Wishbone acknowledge
	input wire logic [15:0] FAN_COUNT, // Measured tach count
	input wire logic [7:0] TEMP, // Selected temperature sample
	input wire logic TEMP_VALID, // One-cycle new sample strobe
	output logic [15:0] TARGET_OUT, // Target count or duty pair
	output logic DUTY_MODE, // High when target low byte is duty
	output logic AUTO_MODE // High when hardware drives target
);
	fan_ctl_pkg::ctl_state_t st_reg; // All registered state
	fan_ctl_pkg::ctl_state_t st_next; // Next value of the state
	fan_ctl_pkg::seg_t seg_new; // Segment chosen by this sample
	logic take; // Bus request accepted this cycle
	logic rd; // Accepted read
	logic wr; // Accepted write with lane 0 selected
	logic [7:0] idx; // Register index from byte address
	logic [7:0] wbyte; // Write data byte
	logic [7:0] sel_val; // Setting of the newly chosen segment
	logic [15:0] calc_count; // Expected count in speed mode
	logic auto_on; // Hardware owns the target bytes
	logic hw_load; // Hardware loads target this cycle

	// Segment comparison with hysteresis
	seg_select u_seg
	(
		.temp(TEMP),
		.bound_up(st_reg.bound_up),
		.bound_lo(st_reg.bound_lo),
		.hyst(st_reg.hyst),
		.cur(st_reg.seg),
		.nxt(seg_new)
	);

	// Relative speed to count conversion
	speed_count_calc u_calc
	(
		.full_count({st_reg.full_hi, st_reg.full_lo}),
		.seg_val(sel_val),
		.expect_count(calc_count)
	);

	// Request decode; one ack per request, dropped the next cycle
	always_comb
	begin
		take = CYC_I & STB_I & ~st_reg.ack;
		rd = take & ~WE_I;
		wr = take & WE_I & SEL_I[0];
		idx = ADR_I[9:2];
		wbyte = DAT_I[7:0];
		auto_on = ~st_reg.cfg.manual;
		hw_load = TEMP_VALID & auto_on;
	end

	// Value of the segment that the new sample selects
	always_comb
	begin
		case (seg_new)
			fan_ctl_pkg::SEG_ONE:
				sel_val = st_reg.seg_one;
			fan_ctl_pkg::SEG_TWO:
				sel_val = st_reg.seg_two;
			fan_ctl_pkg::SEG_THREE:
				sel_val = st_reg.seg_three;
			default:
				sel_val = st_reg.seg_three;
		endcase
	end

	// Next state: bus reads and writes, then hardware updates
	always_comb
	begin
		st_next = st_reg;
		st_next.ack = take;
		// Tach count is sampled every cycle; the shadow is not
		st_next.meas = FAN_COUNT;
		if (take)
		begin
			// Read mux; unmapped indices read zero
			case (idx)
				`IDX_MODE_CFG:
					st_next.rdata = {4'h0, st_reg.cfg.manual,
						st_reg.cfg.duty, 1'b0, st_reg.cfg.neg_en};
				`IDX_MEAS_HI:
					st_next.rdata = st_reg.meas[15:8];
				`IDX_MEAS_LO:
					// Low byte as frozen by the last high-byte read
					st_next.rdata = st_reg.meas_shadow;
				`IDX_TGT_HI:
					// High byte is reserved in duty mode
					st_next.rdata = st_reg.cfg.duty ? 8'h00
						: st_reg.tgt_hi;
				`IDX_TGT_LO:
					st_next.rdata = st_reg.tgt_lo;
				`IDX_FULL_HI:
					st_next.rdata = st_reg.full_hi;
				`IDX_FULL_LO:
					st_next.rdata = st_reg.full_shadow;
				`IDX_BOUND_UP:
					st_next.rdata = st_reg.bound_up;
				`IDX_BOUND_LO:
					st_next.rdata = st_reg.bound_lo;
				`IDX_HYST:
					st_next.rdata = {4'h0, st_reg.hyst};
				`IDX_SEG_ONE:
					st_next.rdata = st_reg.seg_one;
				`IDX_SEG_TWO:
					st_next.rdata = st_reg.seg_two;
				`IDX_SEG_THREE:
					st_next.rdata = st_reg.seg_three;
				default:
					st_next.rdata = 8'h00;
			endcase
		end
		// Read side effects: freeze low bytes against updates
		if (rd && idx == `IDX_MEAS_HI)
			st_next.meas_shadow = st_reg.meas[7:0];
		if (rd && idx == `IDX_FULL_HI)
			st_next.full_shadow = st_reg.full_lo;
		// Register writes; read-only indices ignore writes
		if (wr)
		begin
			case (idx)
				`IDX_MODE_CFG:
				begin
					st_next.cfg.neg_en = wbyte[`CFG_NEG_BIT];
					st_next.cfg.duty = wbyte[`CFG_DUTY_BIT];
					st_next.cfg.manual = wbyte[`CFG_MANUAL_BIT];
				end
				`IDX_TGT_HI:
					// Reserved while in duty mode
					if (!st_reg.cfg.duty)
						st_next.tgt_hi = wbyte;
				`IDX_TGT_LO:
					// Locked to software in speed-count auto mode
					if (st_reg.cfg.duty || st_reg.cfg.manual)
						st_next.tgt_lo = wbyte;
				`IDX_FULL_HI:
					st_next.full_hi = wbyte;
				`IDX_FULL_LO:
				begin
					// Shadow follows so a lone low read is coherent
					st_next.full_lo = wbyte;
					st_next.full_shadow = wbyte;
				end
				`IDX_BOUND_UP:
					st_next.bound_up = wbyte;
				`IDX_BOUND_LO:
					st_next.bound_lo = wbyte;
				`IDX_HYST:
					st_next.hyst = wbyte[3:0];
				`IDX_SEG_ONE:
					st_next.seg_one = wbyte;
				`IDX_SEG_TWO:
					st_next.seg_two = wbyte;
				`IDX_SEG_THREE:
					st_next.seg_three = wbyte;
				default:
					st_next.rdata = st_next.rdata;
			endcase
		end
		// Positive-only boundaries unless negatives are enabled
		if (!st_next.cfg.neg_en)
		begin
			st_next.bound_up[7] = 1'b0;
			st_next.bound_lo[7] = 1'b0;
		end
		// Each new sample re-runs the segment choice
		if (TEMP_VALID)
			st_next.seg = seg_new;
		// Hardware load wins over a same-cycle software write
		if (hw_load)
		begin
			if (st_reg.cfg.duty)
				// Segment byte taken directly as PWM duty
				st_next.tgt_lo = sel_val;
			else
			begin
				// Segment byte taken as relative speed
				st_next.tgt_hi = calc_count[15:8];
				st_next.tgt_lo = calc_count[7:0];
			end
		end
	end

	// State register; constants only under reset
	always_ff @(posedge CLOCK or posedge RST)
	begin
		if (RST)
		begin
			st_reg.ack <= 1'b0;
			st_reg.rdata <= 8'h00;
			st_reg.meas <= `RST_MEAS;
			st_reg.meas_shadow <= `RST_MEAS_SHADOW;
			st_reg.tgt_hi <= `RST_TGT_HI;
			st_reg.tgt_lo <= `RST_TGT_LO;
			st_reg.full_hi <= `RST_FULL_HI;
			st_reg.full_lo <= `RST_FULL_LO;
			st_reg.full_shadow <= `RST_FULL_LO;
			st_reg.bound_up <= `RST_BOUND_UP;
			st_reg.bound_lo <= `RST_BOUND_LO;
			st_reg.hyst <= `RST_HYST;
			st_reg.seg_one <= `RST_SEG_ONE;
			st_reg.seg_two <= `RST_SEG_TWO;
			st_reg.seg_three <= `RST_SEG_THREE;
			st_reg.cfg <= '0;
			st_reg.seg <= fan_ctl_pkg::SEG_THREE;
		end
		else
			st_reg <= st_next;
	end

	// Outputs straight from flops
	always_comb
	begin
		DAT_O = {24'h000000, st_reg.rdata};
		ACK_O = st_reg.ack;
		TARGET_OUT = {st_reg.tgt_hi, st_reg.tgt_lo};
		DUTY_MODE = st_reg.cfg.duty;
		AUTO_MODE = ~st_reg.cfg.manual;
	end

	// Checks on the block's own behaviour
	default clocking cb @(posedge CLOCK);
	endclocking
	default disable iff (RST);

	property p_meas_latch;
		rd && idx == `IDX_MEAS_HI |=> st_reg.meas_shadow == $past(st_reg.meas[7:0]);
	endproperty
	a_meas_latch: assert property (p_meas_latch)
		else $error("Measured low byte not latched on high read");

	property p_meas_low_read;
		rd && idx == `IDX_MEAS_LO |=> DAT_O[7:0] == $past(st_reg.meas_shadow);
	endproperty
	a_meas_low_read: assert property (p_meas_low_read)
		else $error("Measured low read not from latched byte");

	property p_speed_load;
		hw_load && !st_reg.cfg.duty |=> TARGET_OUT == $past(calc_count);
	endproperty
	a_speed_load: assert property (p_speed_load)
		else $error("Speed auto load did not set target count");

	property p_low_locked;
		wr && idx == `IDX_TGT_LO && auto_on && !st_reg.cfg.duty
			&& !TEMP_VALID |=> $stable(st_reg.tgt_lo);
	endproperty
	a_low_locked: assert property (p_low_locked)
		else $error("Low target byte written in speed auto mode");

	property p_hi_reserved;
		rd && idx == `IDX_TGT_HI && st_reg.cfg.duty |=> DAT_O == 32'h0;
	endproperty
	a_hi_reserved: assert property (p_hi_reserved)
		else $error("Reserved high byte read nonzero in duty mode");

	property p_duty_load;
		hw_load && st_reg.cfg.duty |=> st_reg.tgt_lo == $past(sel_val);
	endproperty
	a_duty_load: assert property (p_duty_load)
		else $error("Duty auto load did not take segment value");

	property p_full_latch;
		rd && idx == `IDX_FULL_HI |=> st_reg.full_shadow == $past(st_reg.full_lo);
	endproperty
	a_full_latch: assert property (p_full_latch)
		else $error("Full speed low byte not latched");

	property p_hot_seg;
		TEMP_VALID && $signed(TEMP) > $signed(st_reg.bound_up)
			|=> st_reg.seg == fan_ctl_pkg::SEG_ONE;
	endproperty
	a_hot_seg: assert property (p_hot_seg)
		else $error("Segment one not chosen above upper boundary");

	property p_mid_seg;
		TEMP_VALID && st_reg.seg == fan_ctl_pkg::SEG_THREE
			&& $signed(TEMP) > $signed(st_reg.bound_lo)
			&& $signed(TEMP) <= $signed(st_reg.bound_up)
			|=> st_reg.seg == fan_ctl_pkg::SEG_TWO;
	endproperty
	a_mid_seg: assert property (p_mid_seg)
		else $error("Segment two not chosen above lower boundary");

	property p_pos_bounds;
		!st_reg.cfg.neg_en && !$past(st_reg.cfg.neg_en)
			|-> !st_reg.bound_up[7] && !st_reg.bound_lo[7];
	endproperty
	a_pos_bounds: assert property (p_pos_bounds)
		else $error("Boundary sign bit set with negatives disabled");

	property p_seg_hold;
		!TEMP_VALID |=> $stable(st_reg.seg);
	endproperty
	a_seg_hold: assert property (p_seg_hold)
		else $error("Segment moved without a temperature sample");

	property p_ack_once;
		take |=> ACK_O ##1 !ACK_O;
	endproperty
	a_ack_once: assert property (p_ack_once)
		else $error("Ack not a single cycle after request");

	// Duty loads touch only the low byte; the high byte is reserved
	property p_duty_hi_keep;
		hw_load && st_reg.cfg.duty |=> $stable(st_reg.tgt_hi);
	endproperty
	a_duty_hi_keep: assert property (p_duty_hi_keep)
		else $error("High target byte moved by duty auto load");

	// Manual mode: samples move the segment but never the target
	property p_manual_hold;
		TEMP_VALID && st_reg.cfg.manual && !wr |=> $stable(TARGET_OUT);
	endproperty
	a_manual_hold: assert property (p_manual_hold)
		else $error("Target moved by a sample in manual mode");

	// An unsigned compare would put negatives above every positive boundary
	property p_signed_bound;
		TEMP_VALID && TEMP[7] && !st_reg.bound_up[7]
			&& st_reg.seg != fan_ctl_pkg::SEG_ONE
			|=> st_reg.seg != fan_ctl_pkg::SEG_ONE;
	endproperty
	a_signed_bound: assert property (p_signed_bound)
		else $error("Negative sample taken as above a positive boundary");

	c_hot: cover property (hw_load && seg_new == fan_ctl_pkg::SEG_ONE);
	c_cool: cover property (st_reg.seg == fan_ctl_pkg::SEG_ONE
		##[1:50] st_reg.seg == fan_ctl_pkg::SEG_TWO);
	c_pair: cover property (rd && idx == `IDX_MEAS_HI
		##[2:20] rd && idx == `IDX_MEAS_LO);
	c_duty: cover property (hw_load && st_reg.cfg.duty);
endmodule

// ==== verilog/seg_select.sv ====
// Purpose: Choose the speed segment from temperature and boundaries
// Assumes: All bytes are signed degrees, hysteresis is unsigned
// Notes: Purely combinational; caller registers the result
`timescale 1ns/10ps
module seg_select
(
	input wire logic [7:0] temp, // Sampled temperature
	input wire logic [7:0] bound_up, // Upper boundary
	input wire logic [7:0] bound_lo, // Lower boundary
	input wire logic [3:0] hyst, // Hysteresis in degrees
	input wire fan_ctl_pkg::seg_t cur, // Present segment
	output fan_ctl_pkg::seg_t nxt // Segment after this sample
);
	logic signed [8:0] t9; // Sign-extended temperature
	logic signed [8:0] up9; // Sign-extended upper boundary
	logic signed [8:0] lo9; // Sign-extended lower boundary
	logic signed [8:0] up_rel; // Upper boundary minus hysteresis
	logic signed [8:0] lo_rel; // Lower boundary minus hysteresis
	// Nine bits keep boundary minus hysteresis from wrapping
	always_comb
	begin
		t9 = $signed({temp[7], temp});
		up9 = $signed({bound_up[7], bound_up});
		lo9 = $signed({bound_lo[7], bound_lo});
		up_rel = up9 - $signed({5'h00, hyst});
		lo_rel = lo9 - $signed({5'h00, hyst});
		case (cur)
			fan_ctl_pkg::SEG_ONE:
				// Leave only once below upper boundary minus hysteresis
				if (t9 < up_rel)
					nxt = (t9 < lo_rel) ? fan_ctl_pkg::SEG_THREE
						: fan_ctl_pkg::SEG_TWO;
				else
					nxt = fan_ctl_pkg::SEG_ONE;
			fan_ctl_pkg::SEG_TWO:
				if (t9 > up9)
					nxt = fan_ctl_pkg::SEG_ONE;
				else if (t9 < lo_rel)
					nxt = fan_ctl_pkg::SEG_THREE;
				else
					nxt = fan_ctl_pkg::SEG_TWO;
			fan_ctl_pkg::SEG_THREE:
				if (t9 > up9)
					nxt = fan_ctl_pkg::SEG_ONE;
				else if (t9 > lo9)
					nxt = fan_ctl_pkg::SEG_TWO;
				else
					nxt = fan_ctl_pkg::SEG_THREE;
			default:
				nxt = fan_ctl_pkg::SEG_THREE;
		endcase
	end
endmodule

// ==== verilog/speed_count_calc.sv ====
// Purpose: Expected tach count from full-speed count and segment
// Assumes: Segment byte is (100-X)*32/X for X percent speed
// Notes: Saturates; a slower fan means a larger count
`timescale 1ns/10ps
`include "fan_ctl_cfg.svh"
module speed_count_calc
(
	input wire logic [15:0] full_count, // Count at full speed
	input wire logic [7:0] seg_val, // Relative speed setting
	output logic [15:0] expect_count // Expected tach count
);
	logic [8:0] factor; // 32 plus segment value
	logic [24:0] product; // Full product before scaling
	logic [19:0] scaled; // Product divided by 32
	// Zero setting gives exactly the full-speed count
	always_comb
	begin
		factor = `SPEED_SCALE_BASE + {1'b0, seg_val};
		product = full_count * factor;
		scaled = product[24:`SPEED_SCALE_SHIFT];
		expect_count = (scaled[19:16] != 4'h0) ? 16'hFFFF : scaled[15:0];
	end
endmodule
